// file: src/hcd_pkg.sv
// Package with constants and carrier types of the hard-wired character detector
package hcd_pkg;

  // Bus geometry
  localparam int unsigned HCD_ADR_W = 8;
  localparam int unsigned HCD_DAT_W = 32;
  localparam int unsigned HCD_SEL_W = 4;

  // Character geometry
  localparam int unsigned HCD_CHAR_W = 16;
  localparam int unsigned HCD_BYTE_W = 8;
  localparam int unsigned HCD_NPAT = 3;

  // Register byte addresses
  localparam logic [7:0] HCD_ADR_PAT0 = 8'h00;
  localparam logic [7:0] HCD_ADR_PAT1 = 8'h04;
  localparam logic [7:0] HCD_ADR_PAT2 = 8'h08;
  localparam logic [7:0] HCD_ADR_CTRL = 8'h0c;
  localparam logic [7:0] HCD_ADR_STAT = 8'h10;

  // Control register fields: bit 2k low byte enable, bit 2k+1 high byte enable of pattern k
  localparam int unsigned HCD_CTRL_BEN_LSB = 0;
  localparam int unsigned HCD_CTRL_BEN_W = 6;
  localparam int unsigned HCD_CTRL_SYNC_BIT = 6;
  localparam int unsigned HCD_CTRL_FLAG_BIT = 7;

  // Receiver control status fields
  localparam int unsigned HCD_STAT_IE_BIT = 4;
  localparam int unsigned HCD_STAT_FLAG_LSB = 8;
  localparam int unsigned HCD_STAT_INTR_BIT = 15;

  // Reset values
  localparam logic [15:0] HCD_PAT_RESET = 16'h0000;
  localparam logic [7:0] HCD_CTRL_RESET = 8'h00;

  // Stretched preset pulse
  localparam int unsigned HCD_PULSE_NS = 500;
  localparam int unsigned HCD_CLK_PERIOD_NS = 50;
  localparam int unsigned HCD_PULSE_CYC_RAW = HCD_PULSE_NS / HCD_CLK_PERIOD_NS;
  localparam int unsigned HCD_PULSE_CYCLES = (HCD_PULSE_CYC_RAW < 1) ? 1 : HCD_PULSE_CYC_RAW;
  localparam int unsigned HCD_CNT_W = 4;

  // Static configuration: pattern bits as switch positions (1 = closed)
  typedef struct packed {
    logic [HCD_NPAT-1:0][HCD_CHAR_W-1:0] pat_closed;
    logic [HCD_CTRL_BEN_W-1:0] byte_en;
    logic sync_compare_enable;
    logic detect_flag_enable;
  } hcd_cfg_t;

  // Four detection flags
  typedef struct packed {
    logic sync_match_flag;
    logic pattern2_match_flag;
    logic pattern1_match_flag;
    logic pattern0_match_flag;
  } hcd_flags_t;

endpackage

// file: src/hcd_pattern_match.sv
// One reference pattern compared bit by bit against the received word
`timescale 1ns/1ns
module hcd_pattern_match
  import hcd_pkg::*;
#(
  parameter int unsigned CHAR_W = HCD_CHAR_W,
  parameter int unsigned BYTE_W = HCD_BYTE_W
)
(
  // Received word and switch setting
  input wire logic [CHAR_W-1:0] rx_data,
  input wire logic [CHAR_W-1:0] switch_closed,
  // Byte enables
  input wire logic low_enable,
  input wire logic high_enable,
  // Result
  output logic match
);

  logic [CHAR_W-1:0] bit_agree;
  logic low_match;
  logic high_match;

  // Open switch stands for one, closed for zero, so agreement is data xor closed
  assign bit_agree = rx_data ^ switch_closed;
  // A byte matches only when all its bits agree; a disabled byte is not compared
  assign low_match = ~low_enable | (&bit_agree[BYTE_W-1:0]);
  assign high_match = ~high_enable | (&bit_agree[CHAR_W-1:BYTE_W]);
  // Both bytes disabled leaves a permanent match
  assign match = low_match & high_match;

endmodule

// file: src/hcd_char_detect.sv
// Hard-wired received-character detector with its Wishbone register slave
// How it works
// - Every received bit is compared singly; a byte matches when all eight agree.
// - Open switch means one, closed switch means zero in the comparison.
// - Pattern match needs every enabled byte to match; disabled bytes are skipped.
// - A pattern with both bytes disabled always reports a match.
// - Sync match is sync-compare enable and sync detected together.
// - Any of the four matches counts as a detected character.
// - Strobe rises on detect, flag enable, end of character, framed, not transparent.
// - Transparent mode blocks every flag strobe and interrupt pulse.
// - Strobe captures pattern 0, 1, 2 and sync matches into status bits 8-11.
// - An unframed receiver clears all four flags and holds them clear.
// - Strobe starts a 500 ns pulse presetting the interrupt flag, status bit 15.
// - Interrupt request needs both interrupt flag bit 15 and enable bit 4.
// - While the preset pulse runs, no bus cycle can change the interrupt flag.
// - The option interlock suppresses the four hard-wired flag outputs.
`timescale 1ns/1ns
module hcd_char_detect
  import hcd_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = HCD_PULSE_CYCLES
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [HCD_ADR_W-1:0] WB_ADR_I,
  input wire logic [HCD_SEL_W-1:0] WB_SEL_I,
  input wire logic [HCD_DAT_W-1:0] WB_DAT_I,
  output logic [HCD_DAT_W-1:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Receiver datapath, same clock
  input wire logic [HCD_CHAR_W-1:0] RX_DATA,
  input wire logic RX_FRAMED,
  input wire logic SYNC_DETECTED,
  input wire logic END_OF_CHARACTER,
  input wire logic TRANSPARENT_SUPPRESS,
  // Option interlock pin, asynchronous
  input wire logic OPTION_INTERLOCK,
  // Status outputs
  output logic [3:0] DETECT_FLAGS,
  output logic CHAR_INTERRUPT_FLAG,
  output logic CHAR_INTERRUPT_PRESET_PULSE,
  output logic CHAR_INTERRUPT_REQUEST
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  hcd_cfg_t cfg;
  hcd_flags_t flags;
  logic [HCD_NPAT-1:0] pat_match;
  logic sync_match;
  logic [3:0] match_vec;
  logic detect_cond;
  logic detect_cond_q;
  logic strobe;
  logic [HCD_CNT_W-1:0] pulse_cnt;
  logic pulse_active;
  logic char_interrupt_enable;
  logic char_interrupt_flag;
  logic il_s1;
  logic il_s2;
  logic il_s3;
  logic interlock;
  logic bus_req;
  logic bus_wr;
  logic [15:0] next_stat;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Byte-lane merge of a 16-bit register, used by all pattern writes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [HCD_DAT_W-1:0] wdat,
                                          input logic [HCD_SEL_W-1:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0])
    begin
      res[HCD_BYTE_W-1:0] = wdat[HCD_BYTE_W-1:0];
    end
    if (sel[1])
    begin
      res[HCD_CHAR_W-1:HCD_BYTE_W] = wdat[HCD_CHAR_W-1:HCD_BYTE_W];
    end
    return res;
  endfunction

  // Zero-extend a 16-bit value to the bus width
  function automatic logic [HCD_DAT_W-1:0] ext16(input logic [15:0] v);
    return {{(HCD_DAT_W-16){1'b0}}, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Comparators

  // One comparator per reference pattern
  genvar gi;
  generate
    for (gi = 0; gi < HCD_NPAT; gi++)
    begin : g_pat
      hcd_pattern_match #(
        .CHAR_W(HCD_CHAR_W),
        .BYTE_W(HCD_BYTE_W)
      ) u_match (
        .rx_data(RX_DATA),
        .switch_closed(cfg.pat_closed[gi]),
        .low_enable(cfg.byte_en[2*gi]),
        .high_enable(cfg.byte_en[2*gi+1]),
        .match(pat_match[gi])
      );
    end
  endgenerate

  // Sync comparator
  assign sync_match = cfg.sync_compare_enable & SYNC_DETECTED;
  assign match_vec = {sync_match, pat_match};

  ////////////////////////////////////////////////////////////////////////////
  // Flag strobe

  // Qualified detection; strobe is its rising edge so a long end-of-character fires once
  assign detect_cond = (|match_vec) & cfg.detect_flag_enable & END_OF_CHARACTER
                       & ~TRANSPARENT_SUPPRESS & RX_FRAMED;
  assign strobe = detect_cond & ~detect_cond_q;

  // Edge detector history
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      detect_cond_q <= 1'b0;
    end
    else
    begin
      detect_cond_q <= detect_cond;
    end
  end

  // Detection flags; unframed clear dominates any capture
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      flags <= '0;
    end
    else if (!RX_FRAMED)
    begin
      flags <= '0;
    end
    else if (strobe)
    begin
      flags <= match_vec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interlock synchroniser

  // Three stages; the level moves only once stages two and three agree
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      il_s1 <= 1'b0;
      il_s2 <= 1'b0;
      il_s3 <= 1'b0;
      interlock <= 1'b0;
    end
    else
    begin
      il_s1 <= OPTION_INTERLOCK;
      il_s2 <= il_s1;
      il_s3 <= il_s2;
      if (il_s2 == il_s3)
      begin
        interlock <= il_s3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Preset pulse stretcher

  // A new strobe restarts the pulse; length is PULSE_CYCLES clocks
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      pulse_cnt <= '0;
      pulse_active <= 1'b0;
    end
    else if (strobe)
    begin
      pulse_cnt <= HCD_CNT_W'(PULSE_CYCLES - 1);
      pulse_active <= 1'b1;
    end
    else if (pulse_cnt != '0)
    begin
      pulse_cnt <= pulse_cnt - 1'b1;
    end
    else
    begin
      pulse_active <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  // Writes land on the edge where the master sees ack, while it still holds the request
  assign bus_wr = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O;

  // One registered acknowledge per request, one clock after the request; ack drops the cycle after
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      WB_ACK_O <= 1'b0;
    end
    else
    begin
      WB_ACK_O <= bus_req;
    end
  end

  // Configuration registers
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      cfg.pat_closed <= {HCD_NPAT{HCD_PAT_RESET}};
      {cfg.detect_flag_enable, cfg.sync_compare_enable, cfg.byte_en} <= HCD_CTRL_RESET;
    end
    else if (bus_wr)
    begin
      case (WB_ADR_I)
        HCD_ADR_PAT0: cfg.pat_closed[0] <= merge16(cfg.pat_closed[0], WB_DAT_I, WB_SEL_I);
        HCD_ADR_PAT1: cfg.pat_closed[1] <= merge16(cfg.pat_closed[1], WB_DAT_I, WB_SEL_I);
        HCD_ADR_PAT2: cfg.pat_closed[2] <= merge16(cfg.pat_closed[2], WB_DAT_I, WB_SEL_I);
        HCD_ADR_CTRL:
        begin
          if (WB_SEL_I[0])
          begin
            cfg.byte_en <= WB_DAT_I[HCD_CTRL_BEN_LSB +: HCD_CTRL_BEN_W];
            cfg.sync_compare_enable <= WB_DAT_I[HCD_CTRL_SYNC_BIT];
            cfg.detect_flag_enable <= WB_DAT_I[HCD_CTRL_FLAG_BIT];
          end
        end
        default: ;
      endcase
    end
  end

  // Interrupt enable bit of the status register
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      char_interrupt_enable <= 1'b0;
    end
    else if (bus_wr && WB_ADR_I == HCD_ADR_STAT && WB_SEL_I[0])
    begin
      char_interrupt_enable <= WB_DAT_I[HCD_STAT_IE_BIT];
    end
  end

  // Interrupt flag: preset wins over a write, and the pulse locks out the bus
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      char_interrupt_flag <= 1'b0;
    end
    else if (pulse_active || strobe)
    begin
      char_interrupt_flag <= 1'b1;
    end
    else if (bus_wr && WB_ADR_I == HCD_ADR_STAT && WB_SEL_I[1])
    begin
      char_interrupt_flag <= WB_DAT_I[HCD_STAT_INTR_BIT];
    end
  end

  // Status word as software sees it
  always_comb
  begin
    next_stat = '0;
    next_stat[HCD_STAT_IE_BIT] = char_interrupt_enable;
    next_stat[HCD_STAT_FLAG_LSB +: 4] = interlock ? 4'h0 : flags;
    next_stat[HCD_STAT_INTR_BIT] = char_interrupt_flag;
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      WB_DAT_O <= '0;
    end
    else if (bus_req && !WB_WE_I)
    begin
      case (WB_ADR_I)
        HCD_ADR_PAT0: WB_DAT_O <= ext16(cfg.pat_closed[0]);
        HCD_ADR_PAT1: WB_DAT_O <= ext16(cfg.pat_closed[1]);
        HCD_ADR_PAT2: WB_DAT_O <= ext16(cfg.pat_closed[2]);
        HCD_ADR_CTRL: WB_DAT_O <= ext16({8'h00, cfg.detect_flag_enable, cfg.sync_compare_enable, cfg.byte_en});
        HCD_ADR_STAT: WB_DAT_O <= ext16(next_stat);
        default: WB_DAT_O <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  // Flags lag the internal flags by one clock so the outputs come from flops
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      DETECT_FLAGS <= 4'h0;
      CHAR_INTERRUPT_FLAG <= 1'b0;
      CHAR_INTERRUPT_PRESET_PULSE <= 1'b0;
      CHAR_INTERRUPT_REQUEST <= 1'b0;
    end
    else
    begin
      DETECT_FLAGS <= interlock ? 4'h0 : flags;
      CHAR_INTERRUPT_FLAG <= char_interrupt_flag;
      CHAR_INTERRUPT_PRESET_PULSE <= pulse_active;
      CHAR_INTERRUPT_REQUEST <= char_interrupt_flag & char_interrupt_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  property p_sync_match;
    sync_match == (cfg.sync_compare_enable && SYNC_DETECTED);
  endproperty
  a_sync_match: assert property (p_sync_match) else $error("sync match wrong");

  property p_both_off;
    (cfg.byte_en[1:0] == 2'b00) |-> pat_match[0];
  endproperty
  a_both_off: assert property (p_both_off) else $error("disabled pattern not matching");

  property p_strobe_cause;
    strobe |-> (|match_vec) && cfg.detect_flag_enable && END_OF_CHARACTER && RX_FRAMED;
  endproperty
  a_strobe_cause: assert property (p_strobe_cause) else $error("strobe without cause");

  property p_transparent;
    TRANSPARENT_SUPPRESS |-> !strobe;
  endproperty
  a_transparent: assert property (p_transparent) else $error("strobe in transparent mode");

  property p_capture;
    (strobe && RX_FRAMED) |=> (flags == $past(match_vec)) || !RX_FRAMED;
  endproperty
  a_capture: assert property (p_capture) else $error("flags not captured");

  property p_unframed;
    !RX_FRAMED |=> flags == 4'h0 ##1 DETECT_FLAGS == 4'h0;
  endproperty
  a_unframed: assert property (p_unframed) else $error("flags not cleared when unframed");

  property p_pulse_len;
    strobe ##1 !strobe [*8] |-> pulse_active && char_interrupt_flag;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("preset pulse too short");

  property p_pulse_end;
    strobe ##1 !strobe [*8] ##1 !strobe ##1 !strobe ##1 !strobe |-> !pulse_active;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("preset pulse too long");

  property p_request;
    CHAR_INTERRUPT_REQUEST |-> $past(char_interrupt_flag) && $past(char_interrupt_enable);
  endproperty
  a_request: assert property (p_request) else $error("request without flag and enable");

  property p_lock;
    (pulse_active && bus_wr) |=> char_interrupt_flag;
  endproperty
  a_lock: assert property (p_lock) else $error("bus changed flag during pulse");

  property p_interlock;
    interlock |=> DETECT_FLAGS == 4'h0;
  endproperty
  a_interlock: assert property (p_interlock) else $error("flags not suppressed");

  c_strobe: cover property (strobe && sync_match);
  c_request: cover property (CHAR_INTERRUPT_REQUEST);
  c_locked_write: cover property (pulse_active && bus_wr);
  c_unframed_clear: cover property ((flags != 4'h0) ##1 !RX_FRAMED);

endmodule

// file: test/hcd_rx_model.sv
// Receiver datapath model that presents received characters to the detector
`timescale 1ns/1ns
module hcd_rx_model
  import hcd_pkg::*;
(
  // Clock
  input wire logic CLK,
  // Receiver side toward the detector
  output logic [HCD_CHAR_W-1:0] RX_DATA,
  output logic RX_FRAMED,
  output logic SYNC_DETECTED,
  output logic END_OF_CHARACTER,
  output logic TRANSPARENT_SUPPRESS
);
  // Idle receiver at time zero
  initial
  begin
    RX_DATA = 16'h0000;
    RX_FRAMED = 1'b0;
    SYNC_DETECTED = 1'b0;
    END_OF_CHARACTER = 1'b0;
    TRANSPARENT_SUPPRESS = 1'b0;
  end

  // One character: end of character stands one cycle, then falls so the next can strobe
  task automatic send(input logic [15:0] d, input logic fr, input logic sy, input logic tr);
    @(posedge CLK);
    RX_DATA <= d;
    RX_FRAMED <= fr;
    SYNC_DETECTED <= sy;
    TRANSPARENT_SUPPRESS <= tr;
    END_OF_CHARACTER <= 1'b1;
    @(posedge CLK);
    END_OF_CHARACTER <= 1'b0;
    SYNC_DETECTED <= ~sy; // Sync indication is driven to the inverse of sy after the character
    @(posedge CLK);
  endtask
endmodule

// file: test/tb_top.sv
// Self-checking testbench of the hard-wired character detector
`timescale 1ns/1ns
module tb_top;
  import hcd_pkg::*;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic intl = 1'b0;
  wire logic [31:0] dat_o;
  wire logic ack;
  wire logic [15:0] rx_data;
  wire logic framed, sync_det, eoc, transp;
  wire logic [3:0] flags;
  wire logic int_flag, pulse, int_req;
  int fails = 0;
  int n_checks = 0;
  int seed = 76231;
  int pulse_cnt = 0;
  int pulse_base = 0;
  logic [3:0] exp_q [$];
  logic [15:0] pat [3];
  logic [7:0] ctrl;
  logic [3:0] exp_flags = 4'h0;
  logic exp_int = 1'b0;
  logic [31:0] q;
  logic [15:0] d;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, pulse length counter
  always #25 CLK = ~CLK;
  always @(posedge CLK)
  begin
    if (pulse === 1'b1)
      pulse_cnt <= pulse_cnt + 1;
  end

  hcd_rx_model i_rx (.CLK(CLK), .RX_DATA(rx_data), .RX_FRAMED(framed), .SYNC_DETECTED(sync_det),
    .END_OF_CHARACTER(eoc), .TRANSPARENT_SUPPRESS(transp));

  hcd_char_detect i_dut (.CLK(CLK), .RESET(RESET), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .RX_DATA(rx_data), .RX_FRAMED(framed), .SYNC_DETECTED(sync_det), .END_OF_CHARACTER(eoc),
    .TRANSPARENT_SUPPRESS(transp), .OPTION_INTERLOCK(intl), .DETECT_FLAGS(flags),
    .CHAR_INTERRUPT_FLAG(int_flag), .CHAR_INTERRUPT_PRESET_PULSE(pulse),
    .CHAR_INTERRUPT_REQUEST(int_req));

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Classic single Wishbone cycle; waits for ack under a bound, data taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    dat <= wd;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50)
      fails++;
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge CLK);
  endtask

  // Reference model: reference bit is the inverse of the closed-switch bit
  task automatic char_step(input logic [15:0] c, input logic fr, input logic sy, input logic tr);
    logic [3:0] m;
    logic hit;
    for (int k = 0; k < 3; k++)
      m[k] = (!ctrl[2*k] || c[7:0] == ~pat[k][7:0]) && (!ctrl[2*k+1] || c[15:8] == ~pat[k][15:8]);
    m[3] = ctrl[6] & sy;
    hit = (|m) && ctrl[7] && !tr && fr;
    if (!fr)
      exp_flags = 4'h0;
    else if (hit)
      exp_flags = m;
    if (hit)
      exp_int = 1'b1;
    exp_q.push_back(exp_flags);
    i_rx.send(c, fr, sy, tr);
    repeat (12) @(posedge CLK);
    chk(flags, exp_q.pop_front());
    wb(1'b0, HCD_ADR_STAT, 32'h0, q);
    chk(q[15:8], {exp_int, 3'b000, exp_flags});
    chk(int_flag, exp_int);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole run needs about 1500 cycles, the limit is 20000
  initial
  begin
    #(50 * 20000);
    fails++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    chk({int_flag, int_req, pulse, flags}, 7'h00);
    wb(1'b0, HCD_ADR_CTRL, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b0, HCD_ADR_PAT1, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b1, 8'h20, 32'hffff, q);
    wb(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h0);
    // Random patterns, enables and near-miss characters
    for (int i = 0; i < 40; i++)
    begin
      for (int k = 0; k < 3; k++)
      begin
        pat[k] = 16'($random(seed));
        wb(1'b1, HCD_ADR_PAT0 + 8'(4 * k), {16'h0, pat[k]}, q);
      end
      ctrl = 8'($random(seed));
      ctrl[7] = (i % 5 != 0);
      wb(1'b1, HCD_ADR_CTRL, {24'h0, ctrl}, q);
      wb(1'b0, HCD_ADR_CTRL, 32'h0, q);
      chk(q, {24'h0, ctrl});
      d = ~pat[i % 3];
      if ($random(seed) & 1)
        d[i % 16] = ~d[i % 16];
      char_step(d, i % 7 != 3, 1'($random(seed)), i % 6 == 5);
      wb(1'b1, HCD_ADR_STAT, 32'h0, q);
      exp_int = 1'b0;
    end
    // Interrupt flag locked during the preset pulse, request follows the flag while enabled
    ctrl = 8'h80;
    wb(1'b1, HCD_ADR_CTRL, 32'h80, q);
    pulse_base = pulse_cnt;
    i_rx.send(16'h5a5a, 1'b1, 1'b0, 1'b0);
    wb(1'b1, HCD_ADR_STAT, 32'h0010, q);
    repeat (2) @(posedge CLK);
    chk(int_flag, 1'b1);
    chk(int_req, 1'b1);
    chk(flags, 4'h7);
    repeat (12) @(posedge CLK);
    chk(pulse_cnt - pulse_base, 10);
    wb(1'b1, HCD_ADR_STAT, 32'h0010, q);
    repeat (2) @(posedge CLK);
    chk({int_flag, int_req}, 2'b00);
    // Option interlock hides the flags without losing them
    intl <= 1'b1;
    wb(1'b1, HCD_ADR_CTRL, 32'hc0, q);
    repeat (6) @(posedge CLK);
    i_rx.send(16'h1234, 1'b1, 1'b1, 1'b0);
    repeat (12) @(posedge CLK);
    chk(flags, 4'h0);
    wb(1'b0, HCD_ADR_STAT, 32'h0, q);
    chk(q[11:8], 4'h0);
    intl <= 1'b0;
    repeat (8) @(posedge CLK);
    chk(flags, 4'hf);
    report_and_stop();
  end
endmodule
